// ---- hdl/dcc_map.svh ----
// Constants of the six-channel DMA channel control block
//
// Overview of operation
// RQ1 - Six channels, each with its own readable and writable control register.
// RQ2 - Reset clears every bit of every channel control register.
// RQ3 - Enable starts a block in enable mode; request modes only arm the channel.
// RQ4 - Enable clears itself at transfer end only in auto-clearing modes.
// RQ5 - Software clearing enable mid-transfer stops after the word in flight lands.
// RQ6 - With interrupt enable, block end after counter reload raises interrupt.
// RQ7 - With interrupt enable, software stopping an active transfer raises interrupt.
// RQ8 - Raised interrupt holds until that channel's service; nothing else clears it.
// RQ9 - Service software should clear interrupt enable first in its routine.
// RQ10 - Interrupt enable low means the channel never raises an interrupt.
// RQ11 - Code 000: request-started block, ends at counter reload, clears enable.
// RQ12 - Code 001: one word per request, ends at counter reload, clears enable.
// RQ13 - Code 010: one line per request, ends at counter reload, clears enable.
// RQ14 - Code 011: enable alone starts block, ends at reload, clears enable.
// RQ15 - Code 100: first request starts block; enable stays, waits for requests.
// RQ16 - Code 101: one word per request, reloads, never clears enable.
// RQ17 - Codes 100 and 101 give no end-of-block interrupt.
// RQ18 - Software must not program codes 110 or 111; no transfer starts then.
// RQ19 - Pending channels compete by two-bit priority for the next word.
// RQ20 - Word modes 001 and 101 accept a second request during the first.
`ifndef DCC_MAP_SVH
`define DCC_MAP_SVH

`define DCC_NCH 6
`define DCC_CTL_W 24
`define DCC_CTL_RESET 24'h00_0000
`define DCC_CTL_BASE 5'h00
`define DCC_CTL_STRIDE 5'h04
`define DCC_EN_BIT 23
`define DCC_IRQ_EN_BIT 22
`define DCC_KIND_LSB 19
`define DCC_PRIO_LSB 17
`define DCC_BUS_DATA_W 32

`endif

// ---- hdl/dcc_pkg.sv ----
// Types of the six-channel DMA channel control block
package dcc_pkg;

	typedef enum logic [2:0] {
		KIND_BLK_REQ = 3'h0,
		KIND_WORD_REQ = 3'h1,
		KIND_LINE_REQ = 3'h2,
		KIND_BLK_EN = 3'h3,
		KIND_BLK_HOLD = 3'h4,
		KIND_WORD_HOLD = 3'h5,
		KIND_RSVD6 = 3'h6,
		KIND_RSVD7 = 3'h7
	} dcc_kind_e;

	typedef struct packed {
		logic channel_enable;
		logic completion_irq_enable;
		dcc_kind_e transfer_kind_select;
		logic [1:0] channel_priority;
		logic continuous_hold;
		logic [4:0] request_source_select;
		logic [10:0] other_fields;
	} dcc_ctl_s;

	typedef enum logic {
		BUS_IDLE = 1'b0,
		BUS_ACK = 1'b1
	} dcc_bus_e;

endpackage : dcc_pkg

// ---- hdl/dcc_top.sv ----
// Six-channel DMA channel control: registers, triggers, stop, interrupts, arbitration
//
// Chosen here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "dcc_map.svh"
module dcc_top
	import dcc_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic i_clk_en,
	input wire logic [4:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic [`DCC_NCH-1:0] i_req,
	input wire logic [`DCC_NCH-1:0] i_word_done,
	input wire logic [`DCC_NCH-1:0] i_line_last,
	input wire logic [`DCC_NCH-1:0] i_block_done,
	input wire logic [`DCC_NCH-1:0] i_irq_ack,
	output logic [`DCC_NCH-1:0] o_grant,
	output logic [`DCC_NCH-1:0] o_busy,
	output logic [`DCC_NCH-1:0] o_irq
);

	// Highest priority wins; ties go to the lowest channel number
	function automatic logic [`DCC_NCH-1:0] pick_winner(
		input logic [`DCC_NCH-1:0] want,
		input logic [2*`DCC_NCH-1:0] prios
	);
		logic [`DCC_NCH-1:0] win;
		logic [1:0] best;
		logic found;
		win = '0;
		best = 2'h0;
		found = 1'b0;
		for (int i = 0; i < `DCC_NCH; i++) begin
			if (want[i] && (!found || prios[2*i +: 2] > best)) begin
				win = `DCC_NCH'(1 << i);
				best = prios[2*i +: 2];
				found = 1'b1;
			end
		end
		return win;
	endfunction : pick_winner

	// Byte-lane merge; only the low three lanes hold register bits
	function automatic logic [`DCC_CTL_W-1:0] lane_merge(
		input logic [`DCC_CTL_W-1:0] old,
		input logic [31:0] data,
		input logic [3:0] be
	);
		logic [`DCC_CTL_W-1:0] res;
		res = old;
		for (int b = 0; b < 3; b++) begin
			if (be[b]) begin
				res[8*b +: 8] = data[8*b +: 8];
			end
		end
		return res;
	endfunction : lane_merge

	// Modes whose enable clears itself at block end
	function automatic logic auto_clears(input dcc_kind_e k);
		return (k == KIND_BLK_REQ) || (k == KIND_WORD_REQ) ||
			(k == KIND_LINE_REQ) || (k == KIND_BLK_EN);
	endfunction : auto_clears

	// Modes that move one word per request
	function automatic logic per_word(input dcc_kind_e k);
		return (k == KIND_WORD_REQ) || (k == KIND_WORD_HOLD);
	endfunction : per_word

	dcc_bus_e bus_reg, bus_next;
	logic wait_reg, wait_next;
	logic [31:0] rdata_reg, rdata_next;
	dcc_ctl_s ctl_reg [`DCC_NCH];
	dcc_ctl_s ctl_next [`DCC_NCH];
	logic [`DCC_NCH-1:0] pend_reg, pend_next;
	logic [`DCC_NCH-1:0] req2_reg, req2_next;
	logic [`DCC_NCH-1:0] stop_reg, stop_next;
	logic [`DCC_NCH-1:0] irq_reg, irq_next;
	logic [`DCC_NCH-1:0] grant_reg, grant_next;
	logic [2:0] idx;
	logic idx_ok;
	logic wr_fire;
	logic [2*`DCC_NCH-1:0] prio_vec;

	assign idx = i_avs_address[4:2];
	assign idx_ok = idx < 3'(`DCC_NCH);
	// Write lands only at the edge where waitrequest is seen low
	assign wr_fire = (bus_reg == BUS_ACK) && i_avs_write && idx_ok;

	// Bus slave: one wait state, read data captured with the ack
	always_comb begin
		bus_next = bus_reg;
		rdata_next = rdata_reg;
		case (bus_reg)
			BUS_IDLE: begin
				if (i_avs_read || i_avs_write) begin
					bus_next = BUS_ACK;
					rdata_next = 32'h0000_0000;
					if (i_avs_read && idx_ok) begin
						rdata_next = {8'h00, ctl_reg[idx]}; // [RQ1]
					end
				end
			end
			BUS_ACK: bus_next = BUS_IDLE;
			default: bus_next = BUS_IDLE;
		endcase
		wait_next = (bus_next != BUS_ACK);
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			bus_reg <= BUS_IDLE;
			wait_reg <= 1'b1;
			rdata_reg <= 32'h0000_0000;
		end else if (i_clk_en) begin
			bus_reg <= bus_next;
			wait_reg <= wait_next;
			rdata_reg <= rdata_next;
		end
	end

	assign o_avs_readdata = rdata_reg;
	assign o_avs_waitrequest = wait_reg;

	// Per-channel control; later statements override earlier ones
	always_comb begin
		logic busy;
		logic wdone;
		logic bdone;
		logic irq_set;
		dcc_ctl_s wr_val;
		busy = 1'b0;
		wdone = 1'b0;
		bdone = 1'b0;
		irq_set = 1'b0;
		wr_val = '0;
		prio_vec = '0;
		for (int c = 0; c < `DCC_NCH; c++) begin
			ctl_next[c] = ctl_reg[c];
			pend_next[c] = pend_reg[c];
			req2_next[c] = req2_reg[c];
			stop_next[c] = stop_reg[c];
			busy = pend_reg[c] || grant_reg[c];
			wdone = i_word_done[c] && grant_reg[c];
			bdone = i_block_done[c] && busy;
			irq_set = 1'b0;
			// Arm or start; reserved codes start nothing
			if (ctl_reg[c].channel_enable && !pend_reg[c] && !stop_reg[c]) begin
				case (ctl_reg[c].transfer_kind_select)
					KIND_BLK_REQ, KIND_WORD_REQ, KIND_LINE_REQ,
					KIND_BLK_HOLD, KIND_WORD_HOLD: begin
						pend_next[c] = i_req[c]; // [RQ3] [RQ11] [RQ15]
					end
					KIND_BLK_EN: pend_next[c] = 1'b1; // [RQ3] [RQ14]
					default: pend_next[c] = 1'b0; // [RQ18]
				endcase
			end
			// A request during a word is remembered, not dropped
			if (per_word(ctl_reg[c].transfer_kind_select) && pend_reg[c] &&
				i_req[c]) begin
				req2_next[c] = 1'b1; // [RQ20]
			end
			if (wdone && per_word(ctl_reg[c].transfer_kind_select)) begin
				pend_next[c] = req2_reg[c] || i_req[c]; // [RQ12] [RQ16] [RQ20]
				req2_next[c] = 1'b0;
			end
			if (wdone && ctl_reg[c].transfer_kind_select == KIND_LINE_REQ &&
				i_line_last[c]) begin
				pend_next[c] = 1'b0; // [RQ13]
			end
			// Block end: counter reloaded outside, pulse marks it
			if (bdone) begin
				if (ctl_reg[c].transfer_kind_select != KIND_WORD_HOLD) begin
					pend_next[c] = 1'b0;
					req2_next[c] = 1'b0;
				end
				if (auto_clears(ctl_reg[c].transfer_kind_select)) begin
					ctl_next[c].channel_enable = 1'b0; // [RQ4] [RQ11] [RQ12]
					irq_set = ctl_reg[c].completion_irq_enable; // [RQ6] [RQ17]
				end
			end
			// Pending stop completes once the word in flight is stored
			if (stop_reg[c] && (wdone || !grant_reg[c])) begin
				stop_next[c] = 1'b0; // [RQ5]
				irq_set = irq_set || ctl_reg[c].completion_irq_enable; // [RQ7]
			end
			// Software write: written bytes override hardware changes
			if (wr_fire && idx == 3'(c)) begin
				wr_val = dcc_ctl_s'(lane_merge(ctl_next[c], i_avs_writedata,
					i_avs_byteenable));
				ctl_next[c] = wr_val; // [RQ1]
				if (ctl_reg[c].channel_enable && !wr_val.channel_enable &&
					busy) begin
					pend_next[c] = 1'b0;
					req2_next[c] = 1'b0;
					if (grant_reg[c] && !wdone) begin
						stop_next[c] = 1'b1; // [RQ5]
					end else begin
						irq_set = irq_set || wr_val.completion_irq_enable; // [RQ7]
					end
				end
			end
			// Set wins over service in the same cycle
			irq_next[c] = (irq_reg[c] && !i_irq_ack[c]) || irq_set; // [RQ8] [RQ10]
			prio_vec[2*c +: 2] = ctl_reg[c].channel_priority;
		end
		// One word in flight at a time over the shared datapath
		if (grant_reg != '0) begin
			grant_next = ((grant_reg & i_word_done) != '0) ? '0 : grant_reg; // [RQ5]
		end else begin
			grant_next = pick_winner(pend_next & ~stop_next, prio_vec); // [RQ19]
		end
	end

	// Registers; reset clears every control bit
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			for (int c = 0; c < `DCC_NCH; c++) begin
				ctl_reg[c] <= dcc_ctl_s'(`DCC_CTL_RESET); // [RQ2]
			end
			pend_reg <= '0;
			req2_reg <= '0;
			stop_reg <= '0;
			irq_reg <= '0;
			grant_reg <= '0;
		end else if (i_clk_en) begin
			for (int c = 0; c < `DCC_NCH; c++) begin
				ctl_reg[c] <= ctl_next[c];
			end
			pend_reg <= pend_next;
			req2_reg <= req2_next;
			stop_reg <= stop_next;
			irq_reg <= irq_next;
			grant_reg <= grant_next;
		end
	end

	assign o_grant = grant_reg;
	assign o_busy = pend_reg;
	assign o_irq = irq_reg;

	// Checks; a frozen clock enable suspends them
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst || !i_clk_en);

	a_grant_one_hot: assert property ($onehot0(grant_reg)) // [RQ19]
		else $error("more than one channel granted");

	a_ack_one_wait: assert property (
		(i_avs_read || i_avs_write) && wait_reg && bus_reg == BUS_IDLE
		|=> !wait_reg ##1 wait_reg) // [RQ1]
		else $error("bus answer not one wait state");

	for (genvar g = 0; g < `DCC_NCH; g++) begin : g_chk
		a_irq_sticky: assert property (
			irq_reg[g] && !i_irq_ack[g] |=> irq_reg[g]) // [RQ8]
			else $error("interrupt dropped without service");

		a_irq_gate_en: assert property (
			!irq_reg[g] && !ctl_reg[g].completion_irq_enable &&
			!(wr_fire && idx == 3'(g)) |=> !irq_reg[g]) // [RQ10]
			else $error("interrupt raised while disabled");

		a_auto_clear_en: assert property (
			i_block_done[g] && (pend_reg[g] || grant_reg[g]) &&
			ctl_reg[g].transfer_kind_select inside {KIND_BLK_REQ, KIND_WORD_REQ,
			KIND_LINE_REQ, KIND_BLK_EN} && !(wr_fire && idx == 3'(g))
			|=> !ctl_reg[g].channel_enable) // [RQ4]
			else $error("enable not cleared at block end");

		a_hold_keeps_en: assert property (
			i_block_done[g] && ctl_reg[g].channel_enable &&
			ctl_reg[g].transfer_kind_select inside {KIND_BLK_HOLD, KIND_WORD_HOLD} &&
			!(wr_fire && idx == 3'(g)) |=> ctl_reg[g].channel_enable) // [RQ15] [RQ16]
			else $error("enable cleared in holding mode");

		a_block_end_irq: assert property (
			i_block_done[g] && (pend_reg[g] || grant_reg[g]) &&
			ctl_reg[g].completion_irq_enable && auto_clears(ctl_reg[g].transfer_kind_select)
			|=> irq_reg[g]) // [RQ6]
			else $error("no interrupt at block end");

		a_hold_no_irq: assert property (
			i_block_done[g] && !irq_reg[g] && !stop_reg[g] &&
			ctl_reg[g].transfer_kind_select inside {KIND_BLK_HOLD, KIND_WORD_HOLD} &&
			!(wr_fire && idx == 3'(g)) |=> !irq_reg[g]) // [RQ17]
			else $error("block interrupt in holding mode");

		a_word_in_flight: assert property (
			grant_reg[g] && !i_word_done[g] |=> grant_reg[g]) // [RQ5]
			else $error("grant dropped before word stored");

		a_stop_then_irq: assert property (
			stop_reg[g] && grant_reg[g] && i_word_done[g] &&
			ctl_reg[g].completion_irq_enable |=> !stop_reg[g] && irq_reg[g]) // [RQ7]
			else $error("stop did not end with interrupt");

		a_reserved_idle: assert property (
			!pend_reg[g] && ctl_reg[g].transfer_kind_select inside {KIND_RSVD6, KIND_RSVD7}
			&& !(wr_fire && idx == 3'(g)) |=> !pend_reg[g]) // [RQ18]
			else $error("reserved mode started transfer");

		a_enable_start: assert property (
			ctl_reg[g].channel_enable && !pend_reg[g] && !stop_reg[g] &&
			ctl_reg[g].transfer_kind_select == KIND_BLK_EN |=> pend_reg[g]) // [RQ14]
			else $error("enable mode did not start");

		a_second_req: assert property (
			pend_reg[g] && i_req[g] && per_word(ctl_reg[g].transfer_kind_select) &&
			!(wr_fire && idx == 3'(g)) && !i_block_done[g] &&
			!(grant_reg[g] && i_word_done[g]) |=> req2_reg[g]) // [RQ20]
			else $error("second request lost");
	end

endmodule : dcc_top

// ---- tb/dcc_periph_model.sv ----
// Peripheral and counter model: finishes granted words and ends blocks
`timescale 1ns/1ps
module dcc_periph_model (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic [5:0] i_grant,
	input wire logic [3:0] i_delay,
	input wire logic [3:0] i_words,
	output logic [5:0] o_word_done,
	output logic [5:0] o_line_last,
	output logic [5:0] o_block_done
);
	logic [3:0] wait_reg;
	logic [3:0] cnt_reg;
	// A word costs i_delay + 1 cycles; the last word of a block also reports the reload
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			wait_reg <= 4'h0;
			cnt_reg <= 4'h0;
			o_word_done <= 6'h00;
			o_line_last <= 6'h00;
			o_block_done <= 6'h00;
		end else begin
			o_word_done <= 6'h00;
			o_line_last <= 6'h00;
			o_block_done <= 6'h00;
			if (i_grant != 6'h00 && o_word_done == 6'h00) begin
				wait_reg <= wait_reg + 4'h1;
				if (wait_reg >= i_delay) begin
					wait_reg <= 4'h0;
					o_word_done <= i_grant;
					o_line_last <= i_grant; // Lines are one word long
					cnt_reg <= cnt_reg + 4'h1;
					if (cnt_reg + 4'h1 >= i_words) begin
						cnt_reg <= 4'h0;
						o_block_done <= i_grant;
					end
				end
			end
		end
	end
endmodule : dcc_periph_model

// ---- tb/testbench.sv ----
// Self-checking bench for the six-channel DMA channel control block
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0;
	logic i_nrst = 1'b0;
	logic [4:0] addr = 5'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [31:0] rdata;
	logic waitreq;
	logic [5:0] req = 6'h00;
	logic [5:0] ack = 6'h00;
	logic clk_en = 1'b1;
	logic [3:0] be = 4'hF;
	logic [5:0] wdone, llast, bdone, grant, busy, irq;
	logic [3:0] delay = 4'h0;
	logic [3:0] words = 4'h1;
	int miscompares = 0;
	int check_count = 0;
	int cyc = 0;
	dcc_top dut_u (.i_core_clk(clk), .i_nrst(i_nrst), .i_clk_en(clk_en), .i_avs_address(addr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
		.o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_req(req), .i_word_done(wdone),
		.i_line_last(llast), .i_block_done(bdone), .i_irq_ack(ack), .o_grant(grant),
		.o_busy(busy), .o_irq(irq));
	dcc_periph_model periph_u (.i_core_clk(clk), .i_nrst(i_nrst), .i_grant(grant),
		.i_delay(delay), .i_words(words), .o_word_done(wdone), .o_line_last(llast),
		.o_block_done(bdone));
	always #5 clk = ~clk;
	// Cycle ceiling; the whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t ns: %s got %h expected %h", $time, m, got, exp);
		end
	endtask : chk
	// One Avalon access, held until waitrequest is sampled low at an edge
	task automatic bus(input logic w, input int c, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		addr <= 5'(c * 4);
		wdata <= d;
		do @(posedge clk); while (waitreq !== 1'b0);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : bus
	task automatic wreg(input int c, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, c, d, q);
	endtask : wreg
	task automatic rchk(input int c, input logic [31:0] e, input string m);
		logic [31:0] q;
		bus(1'b0, c, 32'h0000_0000, q);
		chk(q, e, m);
	endtask : rchk
	task automatic wait_busy(input int c, input logic v);
		do @(posedge clk); while (busy[c] !== v);
	endtask : wait_busy
	// Pulses last exactly one cycle so a single event is seen
	task automatic pulse(input int c, input bit is_ack);
		@(posedge clk);
		if (is_ack) ack[c] <= 1'b1;
		else req[c] <= 1'b1;
		@(posedge clk);
		ack[c] <= 1'b0;
		req[c] <= 1'b0;
	endtask : pulse
	task automatic t_regs();
		for (int c = 0; c < 8; c++) rchk(c, 32'h0000_0000, "reset value");
		chk(32'(busy | grant | irq), 32'h0000_0000, "idle after reset");
		for (int c = 0; c < 7; c++) wreg(c, 32'hFF0A_5A50 | 32'(c));
		for (int c = 0; c < 8; c++) rchk(c, (c < 6) ? 32'h000A_5A50 | 32'(c) : 0, "rw");
		// Only lane 1 lands; lane 3 holds no register bits
		be <= 4'hA;
		wreg(0, 32'hFFFF_FFFF);
		be <= 4'hF;
		rchk(0, 32'h000A_FF50, "byte lanes");
		for (int c = 0; c < 6; c++) wreg(c, 32'h0000_0000);
		$display("register test done");
	endtask : t_regs
	// Enable-started block with interrupt, then service of the held interrupt
	task automatic t_block_en();
		words <= 4'h3;
		wreg(0, 32'h00D8_0000);
		wait_busy(0, 1'b1);
		wait_busy(0, 1'b0);
		repeat (2) @(posedge clk);
		rchk(0, 32'h0058_0000, "enable self clear");
		chk(32'(irq), 32'h0000_0001, "block end irq");
		wreg(0, 32'h0000_0000);
		repeat (20) @(posedge clk);
		chk(32'(irq), 32'h0000_0001, "irq held");
		// A frozen clock enable must swallow the service pulse
		clk_en <= 1'b0;
		pulse(0, 1'b1);
		clk_en <= 1'b1;
		chk(32'(irq), 32'h0000_0001, "ack ignored while frozen");
		pulse(0, 1'b1);
		@(posedge clk);
		chk(32'(irq), 32'h0000_0000, "irq serviced");
		$display("enable mode test done");
	endtask : t_block_en
	task automatic t_req_modes();
		delay <= 4'h1;
		words <= 4'h1;
		for (int m = 0; m < 3; m++) begin
			wreg(1, 32'h0080_0000 | 32'(m << 19));
			repeat (6) @(posedge clk);
			chk(32'(busy), 32'h0000_0000, "armed only");
			req[1] <= 1'b1;
			wait_busy(1, 1'b1);
			wait_busy(1, 1'b0);
			req[1] <= 1'b0;
			repeat (2) @(posedge clk);
			rchk(1, 32'(m << 19), "auto clear");
			chk(32'(irq), 32'h0000_0000, "irq disabled");
		end
		$display("request mode test done");
	endtask : t_req_modes
	task automatic t_hold_modes();
		delay <= 4'h2;
		for (int m = 4; m < 6; m++) begin
			wreg(1, 32'h00C0_0000 | 32'(m << 19));
			repeat (2) begin
				pulse(1, 1'b0);
				wait_busy(1, 1'b1);
				wait_busy(1, 1'b0);
			end
			rchk(1, 32'h00C0_0000 | 32'(m << 19), "enable kept");
			chk(32'(irq), 32'h0000_0000, "no block irq");
			wreg(1, 32'h0000_0000);
		end
		// A second word request during the first is kept, not lost
		delay <= 4'h4;
		words <= 4'h8;
		wreg(1, 32'h00A8_0000);
		pulse(1, 1'b0);
		pulse(1, 1'b0);
		do @(posedge clk); while (grant[1] !== 1'b0);
		chk(32'(busy), 32'h0000_0002, "second request kept");
		wait_busy(1, 1'b0);
		wreg(1, 32'h0000_0000);
		words <= 4'h1;
		$display("hold mode test done");
	endtask : t_hold_modes
	// Reserved codes are refused; two armed channels compete by priority
	task automatic t_rsvd_prio();
		for (int m = 6; m < 8; m++) begin
			wreg(3, 32'h0080_0000 | 32'(m << 19));
			req[3] <= 1'b1;
			repeat (8) @(posedge clk);
			chk(32'(busy | grant), 32'h0000_0000, "reserved idle");
			req[3] <= 1'b0;
			wreg(3, 32'h0000_0000);
		end
		wreg(4, 32'h0082_0000);
		wreg(5, 32'h0086_0000);
		req[5:4] <= 2'b11;
		do @(posedge clk); while (grant === 6'h00);
		chk(32'(grant), 32'h0000_0020, "priority winner");
		do @(posedge clk); while (busy[5:4] !== 2'b00);
		req[5:4] <= 2'b00;
		$display("reserved and priority test done");
	endtask : t_rsvd_prio
	// Slow word in flight while software stops the channel
	task automatic t_stop();
		delay <= 4'h8;
		words <= 4'h8;
		wreg(2, 32'h00D8_0000);
		do @(posedge clk); while (grant[2] !== 1'b1);
		wreg(2, 32'h0058_0000);
		chk(32'(grant), 32'h0000_0004, "word in flight");
		do @(posedge clk); while (irq[2] !== 1'b1);
		chk(32'(grant | busy), 32'h0000_0000, "stopped");
		rchk(2, 32'h0058_0000, "enable off");
		wreg(2, 32'h0000_0000);
		pulse(2, 1'b1);
		@(posedge clk);
		chk(32'(irq), 32'h0000_0000, "stop irq serviced");
		$display("stop test done");
	endtask : t_stop
	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (2) @(posedge clk);
		i_nrst <= 1'b1;
		t_regs();
		t_block_en();
		t_req_modes();
		t_hold_modes();
		t_rsvd_prio();
		t_stop();
		report_and_stop();
	end
endmodule : testbench
